// >>> common/ser_cfg.svh
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

// ----------------------------------------------------------------------
// Register bank layout
// ----------------------------------------------------------------------
`define SER_NREG 5
`define SER_R_OPER 3'h0
`define SER_R_QUES 3'h1
`define SER_R_QFRQ 3'h2
`define SER_R_QLIM 3'h3
`define SER_R_QPWR 3'h4
`define SER_P_COND 3'h0
`define SER_P_EVENT 3'h1
`define SER_P_ENABLE 3'h2
`define SER_P_PTR 3'h3
`define SER_P_NTR 3'h4
`define SER_W_CMD 6'h28
`define SER_W_ERRQ 6'h29
`define SER_W_STB 6'h2A
`define SER_W_SRE 6'h2B

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define SER_CMD_PRESET 0
`define SER_CMD_CLEAR 1
`define SER_CMD_RST 2
`define SER_QSUM_FRQ 8
`define SER_QSUM_LIM 9
`define SER_QSUM_PWR 10
`define SER_STB_ERRQ 2
`define SER_STB_QUES 3
`define SER_STB_MAV 4
`define SER_STB_ESB 5
`define SER_STB_OPER 7
`define SER_STB_RQS 6
`define SER_SRQ_MASK 8'hBC
`define SER_ERR_NONE_BIT 16
`define SER_ERR_EMPTY 32'h0001_0000
`define SER_PTR_PRESET 16'hFFFF
`define SER_NTR_PRESET 16'h0000
`define SER_EN_PRESET 16'h0000
`define SER_UNMAPPED 32'h0000_0000

`endif

// >>> common/ser_pkg.sv
package ser_pkg;

   // Avalon-MM request group as the master drives it.
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } ser_av_req_t;

   typedef enum logic {
      SER_BUS_IDLE,
      SER_BUS_ANS
   } ser_bus_t;

endpackage

// >>> rtl/ser_top.sv
`timescale 1ns/10ps
`include "ser_cfg.svh"
// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
module ser_top #(
   parameter int ERRQ_DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire ser_pkg::ser_av_req_t av_req,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   input wire logic [15:0] oper_cal_cond,
   input wire logic [15:0] ques_cond_raw,
   input wire logic [15:0] qfrq_cond_raw,
   input wire logic [15:0] qlim_cond_raw,
   input wire logic [15:0] qpwr_cond_raw,
   input wire logic err_push,
   input wire logic signed [15:0] err_code,
   input wire logic out_avail,
   input wire logic std_event_sum,
   output logic srq,
   output logic inst_reset
);
   import ser_pkg::*;

   localparam int NR = `SER_NREG;
   localparam int AW = $clog2(ERRQ_DEPTH);

   if (ERRQ_DEPTH < 2 || (1 << AW) != ERRQ_DEPTH) begin : g_chk
      $error("ERRQ_DEPTH must be a power of two of at least 2");
   end

   // -------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------
   // Every access answers one cycle after it is taken. Read data are
   // captured when the request is taken and stand through the answer.
   ser_bus_t bus_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic [5:0] word;
   logic [2:0] ridx;
   logic [2:0] part;
   logic reg_hit;
   logic commit;
   logic wr_go;
   logic rd_go;
   logic preset_go;
   logic clear_go;
   logic rst_go;

   assign word = av_req.address[7:2];
   assign ridx = word[5:3];
   assign part = word[2:0];
   assign reg_hit = (ridx < 3'(NR)) && (part <= `SER_P_NTR);
   assign commit = (bus_q == SER_BUS_ANS) && (av_req.read || av_req.write);
   assign wr_go = commit && av_req.write;
   assign rd_go = commit && av_req.read;
   assign preset_go = wr_go && word == `SER_W_CMD &&
                      av_req.writedata[`SER_CMD_PRESET];
   assign clear_go = wr_go && word == `SER_W_CMD &&
                     av_req.writedata[`SER_CMD_CLEAR];
   assign rst_go = wr_go && word == `SER_W_CMD &&
                   av_req.writedata[`SER_CMD_RST];

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_q <= SER_BUS_IDLE;
         wait_q <= 1'b1;
      end else begin
         case (bus_q)
            SER_BUS_IDLE: begin
               if (av_req.read || av_req.write) begin
                  bus_q <= SER_BUS_ANS;
                  wait_q <= 1'b0;
               end
            end
            SER_BUS_ANS: begin
               bus_q <= SER_BUS_IDLE;
               wait_q <= 1'b1;
            end
            default: begin
               bus_q <= SER_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= `SER_UNMAPPED;
      end else if (bus_q == SER_BUS_IDLE && av_req.read) begin
         rdata_q <= rd_mux;
      end
   end

   assign av_readdata = rdata_q;
   assign av_waitrequest = wait_q;

   // -------------------------------------------------------------------
   // Condition inputs
   // -------------------------------------------------------------------
   // Conditions come from instrument pins, so each passes two flops.
   // The bank has no mode input at all, so every measurement mode sees
   // the same registers.
   logic [15:0] raw [NR];
   logic [15:0] sync1_q [NR];
   logic [15:0] sync2_q [NR];
   logic [15:0] cond [NR];
   logic [15:0] prev_q [NR];
   logic [15:0] ev_q [NR];
   logic [15:0] en_q [NR];
   logic [15:0] ptr_q [NR];
   logic [15:0] ntr_q [NR];
   logic [15:0] set [NR];
   logic [NR-1:0] summ;

   assign raw[`SER_R_OPER] = oper_cal_cond;
   assign raw[`SER_R_QUES] = ques_cond_raw;
   assign raw[`SER_R_QFRQ] = qfrq_cond_raw;
   assign raw[`SER_R_QLIM] = qlim_cond_raw;
   assign raw[`SER_R_QPWR] = qpwr_cond_raw;

   always_ff @(posedge clk) begin
      for (int i = 0; i < NR; i++) begin
         if (reset) begin
            sync1_q[i] <= 16'h0000;
            sync2_q[i] <= 16'h0000;
         end else begin
            sync1_q[i] <= raw[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   // Sub-register summaries enter the questionable condition.
   always_comb begin
      for (int i = 0; i < NR; i++) begin
         cond[i] = sync2_q[i];
      end
      cond[`SER_R_QUES][`SER_QSUM_FRQ] = summ[`SER_R_QFRQ];
      cond[`SER_R_QUES][`SER_QSUM_LIM] = summ[`SER_R_QLIM];
      cond[`SER_R_QUES][`SER_QSUM_PWR] = summ[`SER_R_QPWR];
   end

   // -------------------------------------------------------------------
   // Status registers
   // -------------------------------------------------------------------
   // Each of the five registers owns all five parts.
   for (genvar r = 0; r < NR; r++) begin : g_reg
      logic sel;
      logic [15:0] clr;

      assign sel = reg_hit && ridx == 3'(r);
      // Both edge directions are checked through their own filter.
      assign set[r] = (ptr_q[r] & cond[r] & ~prev_q[r]) |
                      (ntr_q[r] & ~cond[r] & prev_q[r]);
      assign summ[r] = |(ev_q[r] & en_q[r]);

      // Only the bits actually returned are cleared, so an event that
      // fires while the read is in flight is not lost.
      assign clr = clear_go ? 16'hFFFF :
                   (rd_go && sel && part == `SER_P_EVENT) ?
                   rdata_q[15:0] : 16'h0000;

      always_ff @(posedge clk) begin
         if (reset) begin
            prev_q[r] <= 16'h0000;
         end else begin
            prev_q[r] <= cond[r];
         end
      end

      // A new set wins over any clear in the same cycle.
      always_ff @(posedge clk) begin
         if (reset) begin
            ev_q[r] <= 16'h0000;
         end else begin
            ev_q[r] <= (ev_q[r] & ~clr) | set[r];
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            en_q[r] <= `SER_EN_PRESET;
         end else if (preset_go) begin
            en_q[r] <= `SER_EN_PRESET;
         end else if (wr_go && sel && part == `SER_P_ENABLE) begin
            en_q[r] <= av_req.writedata[15:0];
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            ptr_q[r] <= `SER_PTR_PRESET;
         end else if (preset_go) begin
            ptr_q[r] <= `SER_PTR_PRESET;
         end else if (wr_go && sel && part == `SER_P_PTR) begin
            ptr_q[r] <= av_req.writedata[15:0];
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            ntr_q[r] <= `SER_NTR_PRESET;
         end else if (preset_go) begin
            ntr_q[r] <= `SER_NTR_PRESET;
         end else if (wr_go && sel && part == `SER_P_NTR) begin
            ntr_q[r] <= av_req.writedata[15:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Error queue
   // -------------------------------------------------------------------
   // When full, new entries are dropped so the oldest causes survive.
   logic signed [15:0] errq_mem [ERRQ_DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign push = err_push && cnt_q != (AW+1)'(ERRQ_DEPTH);
   // Pop only if the captured answer held an entry; an entry that
   // arrives during the access is kept for the next read.
   assign pop = rd_go && word == `SER_W_ERRQ &&
                !rdata_q[`SER_ERR_NONE_BIT];

   always_ff @(posedge clk) begin
      if (push) begin
         errq_mem[wp_q] <= err_code;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (clear_go) begin
            rp_q <= wp_q;
            cnt_q <= (AW+1)'(push);
         end else begin
            if (pop) begin
               rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end

   // -------------------------------------------------------------------
   // Status byte and service request
   // -------------------------------------------------------------------
   logic [7:0] stb;
   logic [7:0] sre_q;
   logic srq_q;
   logic rst_q;

   always_comb begin
      stb = 8'h00;
      stb[`SER_STB_ERRQ] = cnt_q != '0;
      stb[`SER_STB_QUES] = summ[`SER_R_QUES];
      stb[`SER_STB_MAV] = out_avail;
      stb[`SER_STB_ESB] = std_event_sum;
      stb[`SER_STB_OPER] = summ[`SER_R_OPER];
      stb[`SER_STB_RQS] = srq_q;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sre_q <= 8'h00;
      end else if (wr_go && word == `SER_W_SRE) begin
         sre_q <= av_req.writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         srq_q <= 1'b0;
      end else begin
         srq_q <= |(stb & sre_q & `SER_SRQ_MASK);
      end
   end

   // The instrument reset only pulses outward; no status part sees it.
   always_ff @(posedge clk) begin
      if (reset) begin
         rst_q <= 1'b0;
      end else begin
         rst_q <= rst_go;
      end
   end

   assign srq = srq_q;
   assign inst_reset = rst_q;

   // -------------------------------------------------------------------
   // Read multiplexer
   // -------------------------------------------------------------------
   always_comb begin
      rd_mux = `SER_UNMAPPED;
      if (reg_hit) begin
         case (part)
            `SER_P_COND: rd_mux = {16'h0000, cond[ridx]};
            `SER_P_EVENT: rd_mux = {16'h0000, ev_q[ridx]};
            `SER_P_ENABLE: rd_mux = {16'h0000, en_q[ridx]};
            `SER_P_PTR: rd_mux = {16'h0000, ptr_q[ridx]};
            `SER_P_NTR: rd_mux = {16'h0000, ntr_q[ridx]};
            default: rd_mux = `SER_UNMAPPED;
         endcase
      end else if (word == `SER_W_ERRQ) begin
         if (cnt_q == '0) begin
            rd_mux = `SER_ERR_EMPTY;
         end else begin
            rd_mux = {16'h0000, errq_mem[rp_q]};
         end
      end else if (word == `SER_W_STB) begin
         rd_mux = {24'h00_0000, stb};
      end else if (word == `SER_W_SRE) begin
         rd_mux = {24'h00_0000, sre_q};
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_PRESET_PTR: assert property (
      preset_go |=> ptr_q[`SER_R_QLIM] == 16'hFFFF &&
                    ptr_q[`SER_R_OPER] == 16'hFFFF)
      else $error("preset did not fill positive filters");
   AST_PRESET_NTR: assert property (
      preset_go |=> ntr_q[`SER_R_QUES] == 16'h0000 &&
                    ntr_q[`SER_R_QPWR] == 16'h0000)
      else $error("preset did not clear negative filters");
   AST_PRESET_EN: assert property (
      preset_go |=> en_q[`SER_R_OPER] == 16'h0000 &&
                    en_q[`SER_R_QUES] == 16'h0000)
      else $error("preset did not clear enable masks");
   AST_PRESET_KEEP: assert property (
      preset_go |=> ev_q[`SER_R_OPER] ==
                    ($past(ev_q[`SER_R_OPER]) | $past(set[`SER_R_OPER])))
      else $error("preset disturbed the event part");
   AST_RST_KEEP: assert property (
      rst_go && !preset_go |=> $stable(en_q[`SER_R_QUES]) &&
                               $stable(ptr_q[`SER_R_QUES]) &&
                               $stable(ntr_q[`SER_R_QUES]))
      else $error("instrument reset altered status parts");
   AST_ERRQ_EMPTY: assert property (
      bus_q == SER_BUS_IDLE && av_req.read && word == `SER_W_ERRQ &&
      cnt_q == '0 |=> av_readdata == `SER_ERR_EMPTY && !av_waitrequest)
      else $error("empty error queue gave a wrong answer");
   AST_ERRQ_POP: assert property (
      pop && !push && !clear_go |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("error queue read did not remove an entry");
   AST_EV_CLEAR: assert property (
      rd_go && reg_hit && ridx == `SER_R_OPER && part == `SER_P_EVENT &&
      !clear_go |=> ev_q[`SER_R_OPER] == ($past(ev_q[`SER_R_OPER]) &
         ~$past(rdata_q[15:0]) | $past(set[`SER_R_OPER])))
      else $error("event read did not clear returned bits");
   AST_EV_STICKY: assert property (
      set[`SER_R_QFRQ] != 16'h0000 |=>
         (ev_q[`SER_R_QFRQ] & $past(set[`SER_R_QFRQ])) ==
         $past(set[`SER_R_QFRQ]))
      else $error("transition did not set its event bit");
   AST_POS_EDGE: assert property (
      ptr_q[`SER_R_OPER][0] && cond[`SER_R_OPER][0] &&
      !prev_q[`SER_R_OPER][0] |=> ev_q[`SER_R_OPER][0])
      else $error("rising condition was missed");
   AST_SUMMARY: assert property (
      ev_q[`SER_R_QFRQ][0] && en_q[`SER_R_QFRQ][0] |->
         summ[`SER_R_QFRQ] && cond[`SER_R_QUES][`SER_QSUM_FRQ])
      else $error("sub-register summary did not reach parent");
   AST_SRQ: assert property (
      sre_q[`SER_STB_OPER] && summ[`SER_R_OPER] ||
      sre_q[`SER_STB_QUES] && summ[`SER_R_QUES] |=> srq)
      else $error("service request not raised");

endmodule

// >>> sim/ser_ctl_model.sv
`timescale 1ns/10ps
module ser_ctl_model (
   input wire logic clk,
   output ser_pkg::ser_av_req_t av_req,
   input wire logic av_waitrequest,
   input wire logic [31:0] av_readdata
);
   import ser_pkg::*;
   // ------------------------------------------------------------------
   // Controller bus cycles
   // ------------------------------------------------------------------
   initial begin
      av_req = '{read: 1'b0, write: 1'b0, address: 8'hFF, writedata: '1};
   end

   // The bus is left showing inverted values once released, so that a
   // stale address or data word can never pass for a live one.
   // The wait has no limit of its own; a hung slave is ended by the
   // bench watchdog, which then fails the run.
   task automatic xfer(input logic rd, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      av_req <= '{read: rd, write: !rd, address: a, writedata: d};
      @(posedge clk);
      while (av_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = av_readdata;
      av_req <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      logic [31:0] q;
      xfer(1'b0, a, {16'h0000, v}, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b1, a, 32'h0000_0000, q);
   endtask
endmodule

// >>> sim/ser_top_tb_top.sv
`timescale 1ns/10ps
`include "ser_cfg.svh"
module ser_top_tb_top;
   import ser_pkg::*;
   localparam logic [2:0] CO = `SER_P_COND;
   localparam logic [2:0] EV = `SER_P_EVENT;
   localparam logic [2:0] EN = `SER_P_ENABLE;
   localparam logic [2:0] PT = `SER_P_PTR;
   localparam logic [2:0] NT = `SER_P_NTR;
   localparam logic [7:0] A_ERR = {`SER_W_ERRQ, 2'b00};
   localparam logic [7:0] A_CMD = {`SER_W_CMD, 2'b00};
   localparam logic [7:0] A_STB = {`SER_W_STB, 2'b00};
   localparam logic [7:0] A_SRE = {`SER_W_SRE, 2'b00};
   logic clk = 1'b0;
   logic reset = 1'b1;
   ser_av_req_t av_req;
   logic [31:0] av_readdata;
   logic av_waitrequest;
   logic srq;
   logic inst_reset;
   logic [15:0] cnd [5] = '{default: 16'h0000};
   logic err_push = 1'b0;
   logic signed [15:0] err_code = 16'sh0000;
   logic out_avail = 1'b0;
   logic std_event_sum = 1'b0;
   int mismatches = 0;
   int tests_run = 0;
   int pulses = 0;

   always #50 clk = ~clk;

   ser_top #(.ERRQ_DEPTH(8)) u_ser_top (
      .clk(clk), .reset(reset), .av_req(av_req),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
      .oper_cal_cond(cnd[0]), .ques_cond_raw(cnd[1]),
      .qfrq_cond_raw(cnd[2]), .qlim_cond_raw(cnd[3]),
      .qpwr_cond_raw(cnd[4]), .err_push(err_push), .err_code(err_code),
      .out_avail(out_avail), .std_event_sum(std_event_sum),
      .srq(srq), .inst_reset(inst_reset)
   );

   ser_ctl_model u_ser_ctl_model (
      .clk(clk), .av_req(av_req), .av_waitrequest(av_waitrequest),
      .av_readdata(av_readdata)
   );

   always @(posedge clk) begin
      if (inst_reset === 1'b1) begin
         pulses++;
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] ad(input int r, input logic [2:0] p);
      return {3'(r), p, 2'b00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e,
         input string nm);
      logic [31:0] d;
      u_ser_ctl_model.rd(a, d);
      chk(nm, d, e);
   endtask

   task automatic w(input logic [7:0] a, input logic [15:0] v);
      u_ser_ctl_model.wr(a, v);
   endtask

   task automatic push(input logic signed [15:0] c);
      err_code <= c;
      err_push <= 1'b1;
      @(posedge clk);
      err_push <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pop(input logic signed [15:0] c);
      logic [31:0] d;
      u_ser_ctl_model.rd(A_ERR, d);
      chk("error entry", d, {16'h0000, c});
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_reset();
      for (int r = 0; r < `SER_NREG; r++) begin
         rc(ad(r, EN), 32'h0, "enable");
         rc(ad(r, PT), 32'h0000_FFFF, "ptr");
         rc(ad(r, NT), 32'h0, "ntr");
      end
      w(ad(`SER_R_QLIM, EN), 16'hFFFF);
      rc(ad(`SER_R_QLIM, EN), 32'h0000_FFFF, "enable max");
      w(ad(`SER_R_QLIM, EN), 16'h0000);
      rc(A_ERR, 32'h0001_0000, "empty queue");
      rc(8'hFC, 32'h0, "unmapped");
      $display("test reset done");
   endtask

   task automatic test_edges();
      for (int r = 0; r < `SER_NREG; r++) begin
         w(ad(r, NT), 16'h00F0);
         cnd[r] <= 16'h00FF;
         repeat (4) @(posedge clk);
         rc(ad(r, CO), 32'h00FF, "cond high");
         rc(ad(r, EV), 32'h00FF, "rise event");
         rc(ad(r, EV), 32'h0, "event cleared");
         cnd[r] <= 16'h0000;
         repeat (4) @(posedge clk);
         rc(ad(r, CO), 32'h0, "cond low");
         rc(ad(r, EV), 32'h00F0, "fall event");
      end
      $display("test edges done");
   endtask

   task automatic test_summary();
      w(ad(`SER_R_QFRQ, EN), 16'h0001);
      cnd[2] <= 16'h0001;
      repeat (4) @(posedge clk);
      rc(ad(`SER_R_QUES, CO), 32'h0100, "sub summary");
      w(ad(`SER_R_QUES, EN), 16'h0100);
      w(A_SRE, 16'h0008);
      repeat (2) @(posedge clk);
      chk("srq", 32'(srq), 32'h1);
      rc(A_STB, 32'h0048, "status byte");
      w(A_SRE, 16'h0020);
      repeat (2) @(posedge clk);
      chk("srq masked", 32'(srq), 32'h0);
      std_event_sum <= 1'b1;
      repeat (3) @(posedge clk);
      chk("srq esb", 32'(srq), 32'h1);
      std_event_sum <= 1'b0;
      out_avail <= 1'b1;
      w(A_SRE, 16'h0010);
      repeat (2) @(posedge clk);
      chk("srq mav", 32'(srq), 32'h1);
      rc(A_STB, 32'h0058, "status byte mav");
      out_avail <= 1'b0;
      w(A_SRE, 16'h0008);
      $display("test summary done");
   endtask

   task automatic test_preset();
      w(ad(`SER_R_OPER, PT), 16'h00FF);
      w(ad(`SER_R_OPER, NT), 16'h1234);
      w(A_CMD, 16'h0001);
      repeat (3) @(posedge clk);
      chk("srq after preset", 32'(srq), 32'h0);
      for (int r = 0; r < `SER_NREG; r++) begin
         rc(ad(r, PT), 32'h0000_FFFF, "preset ptr");
         rc(ad(r, NT), 32'h0, "preset ntr");
         rc(ad(r, EN), 32'h0, "preset enable");
      end
      rc(ad(`SER_R_QFRQ, CO), 32'h0001, "cond kept");
      rc(ad(`SER_R_QFRQ, EV), 32'h0001, "event kept");
      rc(ad(`SER_R_QUES, EV), 32'h0100, "parent event kept");
      $display("test preset done");
   endtask

   task automatic test_inst_reset();
      int n0;
      w(ad(`SER_R_OPER, EN), 16'h00AA);
      w(ad(`SER_R_OPER, NT), 16'h0055);
      w(ad(`SER_R_OPER, PT), 16'h0F0F);
      cnd[0] <= 16'h0001;
      repeat (4) @(posedge clk);
      n0 = pulses;
      w(A_CMD, 16'h0004);
      repeat (2) @(posedge clk);
      chk("reset pulses", 32'(pulses - n0), 32'h1);
      rc(ad(`SER_R_OPER, EN), 32'h00AA, "enable kept");
      rc(ad(`SER_R_OPER, NT), 32'h0055, "ntr kept");
      rc(ad(`SER_R_OPER, PT), 32'h0F0F, "ptr kept");
      rc(ad(`SER_R_OPER, EV), 32'h0001, "event kept");
      $display("test instrument reset done");
   endtask

   task automatic test_errq();
      push(-16'sd5);
      push(16'sd7);
      push(-16'sd32768);
      rc(A_STB, 32'h0004, "queue flag");
      pop(-16'sd5);
      pop(16'sd7);
      pop(-16'sd32768);
      rc(A_ERR, 32'h0001_0000, "drained");
      push(16'sd3);
      w(ad(`SER_R_QLIM, EN), 16'h0002);
      cnd[3] <= 16'h0002;
      repeat (4) @(posedge clk);
      w(A_CMD, 16'h0002);
      rc(A_ERR, 32'h0001_0000, "queue cleared");
      rc(ad(`SER_R_QLIM, EV), 32'h0, "event cleared");
      rc(ad(`SER_R_QLIM, EN), 32'h0002, "mask kept");
      rc(ad(`SER_R_QLIM, PT), 32'h0000_FFFF, "filter kept");
      $display("test error queue done");
   endtask

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      test_reset();
      test_edges();
      test_summary();
      test_preset();
      test_inst_reset();
      test_errq();
      test_done();
   end

   // The whole run needs well under a thousand accesses of three cycles.
   initial begin
      repeat (6000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule
